// ---- unit_cfg.svh ----
/*
 * constants of the capture/compare/pwm unit: register offsets, field
 * positions, mode codes and reset values.
 * assumes: included by its bare name from the package and each module.
 */
`ifndef UNIT_CFG_SVH
`define UNIT_CFG_SVH

// register byte offsets
`define ADDR_CAP_LOW 8'h13
`define ADDR_CAP_HIGH 8'h14
`define ADDR_MODE_CTRL 8'h15
`define ADDR_DEADBAND 8'h16
`define ADDR_SHUTDOWN 8'h17
`define ADDR_IRQ_STATUS 8'h18
`define ADDR_IRQ_MASK 8'h19

// reset values
`define RST_BYTE 8'h00
`define RST_DUTY 10'h000
`define RST_DEAD 7'h00
`define RST_PRESC 4'h0

// unit_mode_control fields
`define CFG_BIT 7
`define RSVD_BIT 6
`define DUTY_HI 5
`define DUTY_LO 4
`define MODE_HI 3
`define MODE_LO 0
`define CTRL_WMASK 8'hbf

// deadband field of pwm_deadband_control
`define DEAD_HI 6
`define DEAD_LO 0

// interrupt status bit of the match flag
`define IRQ_MATCH_BIT 0
`define IRQ_WMASK 8'h01

// unit_mode_field codes
`define MODE_OFF 4'h0
`define MODE_RSVD1 4'h1
`define MODE_TOGGLE 4'h2
`define MODE_RSVD3 4'h3
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_SET_MATCH 4'h8
`define MODE_CLR_MATCH 4'h9
`define MODE_SOFT_IRQ 4'ha
`define MODE_SPECIAL 4'hb
`define MODE_PWM_HH 4'hc
`define MODE_PWM_HL 4'hd
`define MODE_PWM_LH 4'he
`define MODE_PWM_LL 4'hf

// capture prescaler last counts and step, dead band step
`define PRESC4_LAST 4'h3
`define PRESC16_LAST 4'hf
`define PRESC_STEP 4'h1
`define DEAD_STEP 7'h01

`endif

// ---- unit_pkg.sv ----
/*
 * types of the capture/compare/pwm unit: pin bundle, pwm settings and the
 * state records of each module.
 * assumes: unit_cfg.svh on the include path.
 */
`include "unit_cfg.svh"

package unit_pkg;

    // drive of the two unit pins; enables are low while driven
    typedef struct packed {
        logic first_out;
        logic first_oe_n;
        logic second_out;
        logic second_oe_n;
    } pin_drive_t;

    // settings handed to the pwm generator
    typedef struct packed {
        logic [1:0] pol_low;
        logic half_bridge;
        logic [9:0] duty;
        logic [6:0] dead;
    } pwm_cfg_t;

    typedef struct packed {
        logic prev_ff;
        logic [3:0] mode_ff;
        logic [3:0] cnt_ff;
    } cap_state_t;

    typedef struct packed {
        logic [9:0] duty_ff;
        logic raw_ff;
        logic [6:0] dead_ff;
        logic a_on_ff;
        logic b_on_ff;
        logic a_out_ff;
        logic b_out_ff;
    } pwm_state_t;

    typedef struct packed {
        logic [7:0] cap_low_ff;
        logic [7:0] cap_high_ff;
        logic [7:0] ctrl_ff;
        logic [7:0] dead_ctl_ff;
        logic [7:0] shut_ctl_ff;
        logic [7:0] stat_ff;
        logic [7:0] mask_ff;
        logic [7:0] rdata_ff;
        logic out_ff;
        logic prev_match_ff;
        logic tmr_rst_ff;
        logic adc_go_ff;
    } top_state_t;

endpackage : unit_pkg

// ---- unit_capture_sel.sv ----
/*
 * edge selector and prescaler of capture mode; gives a one-cycle hit in
 * the cycle whose edge must be captured.
 * assumes: pin input synchronous to ref_clk.
 */
`timescale 1ns/1ps
`include "unit_cfg.svh"

module unit_capture_sel
    import unit_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic enable,
    input wire logic [3:0] mode,
    input wire logic pin_in,
    output logic hit
);

    cap_state_t st_ff;
    cap_state_t nxt_st;
    logic rise;
    logic fall;

    // edge detect and prescale count
    always_comb
    begin
        nxt_st = st_ff;
        hit = 1'b0;
        rise = pin_in & ~st_ff.prev_ff;
        fall = ~pin_in & st_ff.prev_ff;
        nxt_st.prev_ff = pin_in;
        nxt_st.mode_ff = mode;
        if (!enable || mode != st_ff.mode_ff)
        begin
            nxt_st.cnt_ff = `RST_PRESC; // a new mode restarts the prescaler
        end
        else
        begin
            unique case (mode)
                `MODE_CAP_FALL: hit = fall;
                `MODE_CAP_RISE: hit = rise;
                `MODE_CAP_RISE4:
                begin
                    if (rise)
                    begin
                        hit = (st_ff.cnt_ff == `PRESC4_LAST);
                        nxt_st.cnt_ff = hit ? `RST_PRESC : st_ff.cnt_ff + `PRESC_STEP;
                    end
                end
                `MODE_CAP_RISE16:
                begin
                    if (rise)
                    begin
                        hit = (st_ff.cnt_ff == `PRESC16_LAST);
                        nxt_st.cnt_ff = st_ff.cnt_ff + `PRESC_STEP;
                    end
                end
                default: hit = 1'b0;
            endcase
        end
        hit = hit & ce;
    end

    // state register, frozen while ce is low
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

endmodule : unit_capture_sel

// ---- unit_pwm_gen.sv ----
/*
 * pwm generator on the second timer: 10-bit duty, dead band in half-bridge
 * use and one polarity per output.
 * assumes: the second timer gives its count, two fine bits and a one-cycle
 * pulse at the start of each period.
 */
`timescale 1ns/1ps
`include "unit_cfg.svh"

module unit_pwm_gen
    import unit_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic enable,
    input wire pwm_cfg_t cfg,
    input wire logic [7:0] tmr,
    input wire logic [1:0] fine,
    input wire logic period_start,
    output logic first_on,
    output logic second_on,
    output logic first_out,
    output logic second_out
);

    pwm_state_t st_ff;
    pwm_state_t nxt_st;
    logic raw_now;

    // duty compare, dead band and polarity
    always_comb
    begin
        nxt_st = st_ff;
        raw_now = ({tmr, fine} < st_ff.duty_ff);
        if (!enable)
        begin
            nxt_st = '0;
        end
        else
        begin
            if (period_start)
                nxt_st.duty_ff = cfg.duty; // new duty takes effect per period
            if (raw_now != st_ff.raw_ff)
            begin
                nxt_st.raw_ff = raw_now;
                nxt_st.dead_ff = cfg.half_bridge ? cfg.dead : `RST_DEAD;
            end
            else if (st_ff.dead_ff != `RST_DEAD)
                nxt_st.dead_ff = st_ff.dead_ff - `DEAD_STEP;
            nxt_st.a_on_ff = raw_now & (nxt_st.dead_ff == `RST_DEAD);
            nxt_st.b_on_ff = cfg.half_bridge & ~raw_now & (nxt_st.dead_ff == `RST_DEAD);
            nxt_st.a_out_ff = nxt_st.a_on_ff ^ cfg.pol_low[1];
            nxt_st.b_out_ff = nxt_st.b_on_ff ^ cfg.pol_low[0];
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    assign first_on = st_ff.a_on_ff;
    assign second_on = st_ff.b_on_ff;
    assign first_out = st_ff.a_out_ff;
    assign second_out = st_ff.b_out_ff;

endmodule : unit_pwm_gen

// ---- unit_ccp_top.sv ----
/*
 * capture/compare/pwm unit: register file, mode decode, compare logic,
 * capture loading, pin control and interrupt.
 * assumes: timers live outside and give their counts synchronously; the
 * register port is a single-cycle strobe bus with read data one cycle later.
 */
`timescale 1ns/1ps
`include "unit_cfg.svh"

module unit_ccp_top
    import unit_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] first_timer_count,
    input wire logic [7:0] second_timer_count,
    input wire logic [1:0] second_timer_fine,
    input wire logic second_timer_period_start,
    input wire logic unit_pin_in,
    input wire logic adc_enabled,
    output pin_drive_t pin_drive,
    output logic first_timer_reset,
    output logic adc_start,
    output logic irq
);

    top_state_t st_ff;
    top_state_t nxt_st;
    logic [3:0] mode;
    logic unit_on;
    logic is_capture;
    logic is_compare;
    logic is_pwm;
    logic cap_hit;
    logic match_now;
    logic fire;
    logic drives_pin;
    logic pwm_first_on;
    logic pwm_second_on;
    logic pwm_first_out;
    logic pwm_second_out;
    pwm_cfg_t pwm_cfg;

    // mode decode
    always_comb
    begin
        mode = st_ff.ctrl_ff[`MODE_HI:`MODE_LO];
        unit_on = (mode != `MODE_OFF);
        is_capture = 1'b0;
        is_compare = 1'b0;
        is_pwm = 1'b0;
        drives_pin = 1'b0;
        unique case (mode)
            `MODE_OFF, `MODE_RSVD1, `MODE_RSVD3: is_capture = 1'b0;
            `MODE_CAP_FALL, `MODE_CAP_RISE, `MODE_CAP_RISE4, `MODE_CAP_RISE16:
                is_capture = 1'b1;
            `MODE_TOGGLE, `MODE_SET_MATCH, `MODE_CLR_MATCH, `MODE_SOFT_IRQ, `MODE_SPECIAL:
            begin
                is_compare = 1'b1;
                drives_pin = 1'b1;
            end
            `MODE_PWM_HH, `MODE_PWM_HL, `MODE_PWM_LH, `MODE_PWM_LL: is_pwm = 1'b1;
        endcase
    end

    // compare against the first timer, acting once per match
    assign match_now = (first_timer_count == {st_ff.cap_high_ff, st_ff.cap_low_ff});
    assign fire = ce & is_compare & match_now & ~st_ff.prev_match_ff;

    // pwm settings; duty low bits only matter here
    always_comb
    begin
        pwm_cfg.pol_low = mode[1:0];
        pwm_cfg.half_bridge = st_ff.ctrl_ff[`CFG_BIT];
        pwm_cfg.duty = {st_ff.cap_low_ff, st_ff.ctrl_ff[`DUTY_HI:`DUTY_LO]};
        pwm_cfg.dead = st_ff.dead_ctl_ff[`DEAD_HI:`DEAD_LO];
    end

    unit_capture_sel u_capture (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .enable(is_capture),
        .mode(mode),
        .pin_in(unit_pin_in),
        .hit(cap_hit)
    );

    unit_pwm_gen u_pwm (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(ce),
        .enable(is_pwm),
        .cfg(pwm_cfg),
        .tmr(second_timer_count),
        .fine(second_timer_fine),
        .period_start(second_timer_period_start),
        .first_on(pwm_first_on),
        .second_on(pwm_second_on),
        .first_out(pwm_first_out),
        .second_out(pwm_second_out)
    );

    // register file, compare actions, capture loads and read port
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rdata_ff = `RST_BYTE;
        nxt_st.tmr_rst_ff = 1'b0;
        nxt_st.adc_go_ff = 1'b0;
        nxt_st.prev_match_ff = is_compare & match_now;
        // off clears the pin level and the match history; a mode write below still presets the pin
        if (!unit_on)
        begin
            nxt_st.out_ff = 1'b0;
            nxt_st.prev_match_ff = 1'b0;
        end
        // write port; unmapped addresses are ignored
        if (reg_wr)
        begin
            unique case (reg_addr)
                `ADDR_CAP_LOW: nxt_st.cap_low_ff = reg_wdata;
                `ADDR_CAP_HIGH: nxt_st.cap_high_ff = reg_wdata;
                `ADDR_MODE_CTRL:
                begin
                    nxt_st.ctrl_ff = reg_wdata & `CTRL_WMASK;
                    // starting level of the pin in set and clear modes
                    if (reg_wdata[`MODE_HI:`MODE_LO] == `MODE_SET_MATCH)
                        nxt_st.out_ff = 1'b0;
                    if (reg_wdata[`MODE_HI:`MODE_LO] == `MODE_CLR_MATCH)
                        nxt_st.out_ff = 1'b1;
                end
                `ADDR_DEADBAND: nxt_st.dead_ctl_ff = reg_wdata;
                `ADDR_SHUTDOWN: nxt_st.shut_ctl_ff = reg_wdata;
                `ADDR_IRQ_STATUS: nxt_st.stat_ff = st_ff.stat_ff & ~(reg_wdata & `IRQ_WMASK);
                `ADDR_IRQ_MASK: nxt_st.mask_ff = reg_wdata & `IRQ_WMASK;
                default: nxt_st.rdata_ff = `RST_BYTE;
            endcase
        end
        // read port; data stands one cycle, then zero
        if (reg_rd)
        begin
            unique case (reg_addr)
                `ADDR_CAP_LOW: nxt_st.rdata_ff = st_ff.cap_low_ff;
                `ADDR_CAP_HIGH: nxt_st.rdata_ff = st_ff.cap_high_ff;
                `ADDR_MODE_CTRL: nxt_st.rdata_ff = st_ff.ctrl_ff & `CTRL_WMASK;
                `ADDR_DEADBAND: nxt_st.rdata_ff = st_ff.dead_ctl_ff;
                `ADDR_SHUTDOWN: nxt_st.rdata_ff = st_ff.shut_ctl_ff;
                `ADDR_IRQ_STATUS: nxt_st.rdata_ff = st_ff.stat_ff;
                `ADDR_IRQ_MASK: nxt_st.rdata_ff = st_ff.mask_ff;
                default: nxt_st.rdata_ff = `RST_BYTE; // unmapped reads zero
            endcase
        end
        // capture overrides a software write in the same cycle
        if (cap_hit)
        begin
            nxt_st.cap_low_ff = first_timer_count[7:0];
            nxt_st.cap_high_ff = first_timer_count[15:8];
            nxt_st.stat_ff[`IRQ_MATCH_BIT] = 1'b1;
        end
        if (fire)
        begin
            nxt_st.stat_ff[`IRQ_MATCH_BIT] = 1'b1; // set wins over clear
            unique case (mode)
                `MODE_TOGGLE: nxt_st.out_ff = ~st_ff.out_ff;
                `MODE_SET_MATCH: nxt_st.out_ff = 1'b1;
                `MODE_CLR_MATCH: nxt_st.out_ff = 1'b0;
                `MODE_SPECIAL:
                begin
                    nxt_st.tmr_rst_ff = 1'b1;
                    nxt_st.adc_go_ff = adc_enabled;
                end
                default: nxt_st.out_ff = st_ff.out_ff; // irq-only leaves the pin
            endcase
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    // pin control per mode
    always_comb
    begin
        pin_drive.first_out = is_pwm ? pwm_first_out : st_ff.out_ff;
        pin_drive.first_oe_n = ~(drives_pin | is_pwm);
        pin_drive.second_out = pwm_second_out;
        pin_drive.second_oe_n = ~(is_pwm & st_ff.ctrl_ff[`CFG_BIT]);
    end

    assign reg_rdata = st_ff.rdata_ff;
    assign first_timer_reset = st_ff.tmr_rst_ff;
    assign adc_start = st_ff.adc_go_ff;
    assign irq = |(st_ff.stat_ff & st_ff.mask_ff);

    // helper: rises counted while the sixteen-edge mode holds
    logic h_prev_pin;
    logic [3:0] h_prev_mode;
    logic [3:0] h_rise_cnt;
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            h_prev_pin <= 1'b0;
            h_prev_mode <= `MODE_OFF;
            h_rise_cnt <= `RST_PRESC;
        end
        else if (ce)
        begin
            h_prev_pin <= unit_pin_in;
            h_prev_mode <= mode;
            if (mode != `MODE_CAP_RISE16 || h_prev_mode != `MODE_CAP_RISE16)
                h_rise_cnt <= `RST_PRESC;
            else if (unit_pin_in && !h_prev_pin)
                h_rise_cnt <= h_rise_cnt + `PRESC_STEP;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    off_quiet_a: assert property ((mode == `MODE_OFF) |->
        (pin_drive.first_oe_n && pin_drive.second_oe_n && !first_timer_reset && !cap_hit))
        else $error("unit active while off");
    toggle_match_a: assert property ((fire && mode == `MODE_TOGGLE) |=>
        (st_ff.out_ff != $past(st_ff.out_ff) && st_ff.stat_ff[`IRQ_MATCH_BIT]))
        else $error("toggle compare did not invert pin and flag");
    fall_load_a: assert property ((cap_hit && mode == `MODE_CAP_FALL) |=>
        ({st_ff.cap_high_ff, st_ff.cap_low_ff} == $past(first_timer_count)))
        else $error("falling edge capture lost timer value");
    fall_every_a: assert property ((ce && mode == `MODE_CAP_FALL && $past(mode) == mode
        && $past(unit_pin_in) && !unit_pin_in && $past(ce)) |-> cap_hit)
        else $error("falling edge not captured");
    edge16_count_a: assert property ((cap_hit && mode == `MODE_CAP_RISE16) |->
        (h_rise_cnt == `PRESC16_LAST))
        else $error("sixteen edge capture at wrong edge");
    clear_match_a: assert property ((fire && mode == `MODE_CLR_MATCH) |=>
        (!st_ff.out_ff && !pin_drive.first_out && st_ff.stat_ff[`IRQ_MATCH_BIT]))
        else $error("clear on match failed");
    special_evt_a: assert property ((fire && mode == `MODE_SPECIAL) |=>
        (first_timer_reset && adc_start == $past(adc_enabled) && st_ff.stat_ff[`IRQ_MATCH_BIT])
        ##1 !first_timer_reset)
        else $error("special event pulses wrong");
    pol_high_a: assert property ((mode == `MODE_PWM_HH && $past(mode) == `MODE_PWM_HH) |->
        (pwm_first_out == pwm_first_on && pwm_second_out == pwm_second_on))
        else $error("active high pwm polarity wrong");
    pol_low_a: assert property ((mode == `MODE_PWM_LL && $past(mode) == `MODE_PWM_LL) |->
        (pwm_first_out == !pwm_first_on && pwm_second_out == !pwm_second_on))
        else $error("active low pwm polarity wrong");
    bit6_zero_a: assert property ((reg_rd && reg_addr == `ADDR_MODE_CTRL) |=>
        !reg_rdata[`RSVD_BIT])
        else $error("reserved control bit read as one");
    flag_set_wins_a: assert property ((fire && reg_wr && reg_addr == `ADDR_IRQ_STATUS)
        |=> st_ff.stat_ff[`IRQ_MATCH_BIT])
        else $error("match lost against clear");

    // pin ownership and enable hold
    port_pin_a: assert property (!(is_pwm && st_ff.ctrl_ff[`CFG_BIT]) |->
        pin_drive.second_oe_n)
        else $error("second pin driven outside half bridge");
    freeze_hold_a: assert property (!ce |=> $stable(st_ff))
        else $error("state moved while disabled");

    // main scenarios reached

    toggle_seen_c: cover property (fire && mode == `MODE_TOGGLE);
    cap16_seen_c: cover property (cap_hit && mode == `MODE_CAP_RISE16);
    half_bridge_c: cover property (is_pwm && !pin_drive.second_oe_n && pwm_second_on);
    special_adc_c: cover property (adc_start);
    fall_capture_c: cover property (cap_hit && mode == `MODE_CAP_FALL);

endmodule : unit_ccp_top

// ---- timer_pin_model.sv ----
/* far-side model of the unit: the free-running first timer and the
   second timer with its fine bits and period pulse.
   assumes one clock shared with the unit. */
`timescale 1ns/1ps

module timer_pin_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tmr_clear,
    output logic [15:0] first_count,
    output logic [9:0] second_full,
    output logic period_start
);
    // first timer restarts on the special event pulse
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            first_count <= 16'h0000;
        end
        else if (tmr_clear)
        begin
            first_count <= 16'h0000;
        end
        else
        begin
            first_count <= first_count + 16'h0001;
        end
    end

    // second timer: count over two fine bits, wraps every 1024 cycles
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            second_full <= 10'h000;
        end
        else
        begin
            second_full <= second_full + 10'h001;
        end
    end

    assign period_start = (second_full == 10'h000); // period pulse at count zero
endmodule : timer_pin_model

// ---- enhanced_capture_compare_pwm_ctrl_bench.sv ----
/* self-checking bench of the unit: registers, compare, capture, pwm.
   assumes the timer model beside it and one 25 MHz clock. */
`timescale 1ns/1ps
`include "unit_cfg.svh"

module enhanced_capture_compare_pwm_ctrl_bench
    import unit_pkg::*;
();
    logic ref_clk, nrst, reg_wr, reg_rd, unit_pin_in, adc_enabled, exp_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, hi;
    logic [15:0] first_count, tgt, rise_t, fall_t;
    logic [9:0] second_full, duty;
    logic period_start, first_timer_reset, adc_start, irq;
    logic [3:0] m;
    pin_drive_t pin_drive;
    int failures, checked, seed, n;
    logic [3:0] cmodes [6] = '{4'h9, 4'h2, 4'ha, 4'h8, 4'hb, 4'hb};

    unit_ccp_top dut_u (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ce(1'b1),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .first_timer_count(first_count),
        .second_timer_count(second_full[9:2]),
        .second_timer_fine(second_full[1:0]),
        .second_timer_period_start(period_start),
        .unit_pin_in(unit_pin_in),
        .adc_enabled(adc_enabled),
        .pin_drive(pin_drive),
        .first_timer_reset(first_timer_reset),
        .adc_start(adc_start),
        .irq(irq)
    );

    timer_pin_model tm_u (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tmr_clear(first_timer_reset),
        .first_count(first_count),
        .second_full(second_full),
        .period_start(period_start)
    );

    // pin level a compare match leaves behind
    function automatic logic cmp_pin(input logic [3:0] md, input logic p);
        case (md)
            `MODE_TOGGLE: return ~p;
            `MODE_SET_MATCH: return 1'b1;
            `MODE_CLR_MATCH: return 1'b0;
            default: return p;
        endcase
    endfunction : cmp_pin

    // edges counted per capture for each capture code
    function automatic int edges_per(input logic [3:0] md);
        return (md == `MODE_CAP_RISE16) ? 16 : (md == `MODE_CAP_RISE4) ? 4 : 1;
    endfunction : edges_per

    // first pin level for a pwm code, active or not
    function automatic logic pwm_lvl(input logic [3:0] md, input logic on);
        return on ^ md[1];
    endfunction : pwm_lvl

    task automatic report_and_stop;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic chk_bit(input string what, input logic e, input logic g);
        chk(what, {15'h0000, e}, {15'h0000, g});
    endtask : chk_bit

    // bus cycles: signals change right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : rd

    // bounded waits; running out counts a mismatch and ends the run
    task automatic wait_full(input logic [9:0] v);
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (second_full !== v && n < 2100);
        chk("timer wait", {6'h00, v}, {6'h00, second_full});
        if (second_full !== v) report_and_stop();
    endtask : wait_full

    task automatic wait_irq;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (irq !== 1'b1 && n < 300);
        chk_bit("irq wait", 1'b1, irq);
        if (irq !== 1'b1) report_and_stop();
    endtask : wait_irq

    // one-cycle high pulse on the pin; timer values of both edge cycles
    task automatic pulse;
        @(posedge ref_clk);
        unit_pin_in <= 1'b1;
        @(negedge ref_clk);
        rise_t = first_count;
        @(posedge ref_clk);
        unit_pin_in <= 1'b0;
        @(negedge ref_clk);
        fall_t = first_count;
    endtask : pulse

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        seed = 5576;
        failures = 0;
        checked = 0;
        {nrst, reg_wr, reg_rd, unit_pin_in, adc_enabled, exp_pin} = 6'h00;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values, read-back, reserved bit, unmapped address
        for (int a = 8'h15; a <= 8'h19; a++)
        begin
            rd(8'(a), rv);
            chk("reset value", 16'h0000, {8'h00, rv});
        end
        rv = 8'($random(seed));
        wr(`ADDR_MODE_CTRL, rv);
        wr(`ADDR_DEADBAND, ~rv);
        wr(8'h20, rv);
        wr(`ADDR_IRQ_MASK, 8'hff);
        rd(`ADDR_MODE_CTRL, hi);
        chk("mode control", {8'h00, rv & `CTRL_WMASK}, {8'h00, hi});
        rd(`ADDR_DEADBAND, hi);
        chk("dead band", {8'h00, ~rv}, {8'h00, hi});
        rd(8'h20, hi);
        chk("unmapped", 16'h0000, {8'h00, hi});
        rd(`ADDR_IRQ_MASK, hi);
        chk("irq mask", 16'h0001, {8'h00, hi});
        wr(`ADDR_MODE_CTRL, 8'h00);
        wr(`ADDR_DEADBAND, 8'h00);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        $display("test registers done");
        // compare codes in turn; each match acts once on the flag, and on the pin in toggle, set and clear codes
        foreach (cmodes[i])
        begin
            m = cmodes[i];
            @(negedge ref_clk);
            tgt = first_count + 16'h0060;
            wr(`ADDR_CAP_HIGH, tgt[15:8]);
            wr(`ADDR_CAP_LOW, tgt[7:0]);
            wr(`ADDR_MODE_CTRL, {4'h0, m});
            adc_enabled <= 1'(i);
            if (m == `MODE_SET_MATCH) exp_pin = 1'b0;
            if (m == `MODE_CLR_MATCH) exp_pin = 1'b1;
            @(negedge ref_clk);
            if (m != `MODE_SPECIAL) chk_bit("preset pin", exp_pin, pin_drive.first_out);
            wait_irq();
            exp_pin = cmp_pin(m, exp_pin);
            if (m != `MODE_SPECIAL) chk_bit("match pin", exp_pin, pin_drive.first_out);
            chk_bit("timer reset", m == `MODE_SPECIAL, first_timer_reset);
            chk_bit("adc start", m == `MODE_SPECIAL && adc_enabled, adc_start);
            wr(`ADDR_IRQ_MASK, 8'h00);
            @(negedge ref_clk);
            chk_bit("masked irq", 1'b0, irq);
            rd(`ADDR_IRQ_STATUS, rv);
            chk("match flag", 16'h0001, {8'h00, rv});
            wr(`ADDR_IRQ_MASK, 8'h01);
            wr(`ADDR_IRQ_STATUS, 8'h01);
            @(negedge ref_clk);
            chk_bit("cleared irq", 1'b0, irq);
        end
        wr(`ADDR_MODE_CTRL, 8'h00);
        repeat (2) @(negedge ref_clk);
        chk("off pins", 16'h0003, {13'h0000, pin_drive.first_out, pin_drive.first_oe_n,
            pin_drive.second_oe_n});
        $display("test compare done");
        // capture on falling, every, fourth and sixteenth rising edge
        for (int c = 4; c <= 7; c++)
        begin
            m = 4'(c);
            wr(`ADDR_MODE_CTRL, {4'h0, m});
            wr(`ADDR_IRQ_STATUS, 8'h01);
            for (int p = 1; p < edges_per(m); p++) pulse();
            rd(`ADDR_IRQ_STATUS, rv);
            chk("early capture", 16'h0000, {8'h00, rv});
            chk_bit("capture pin input", 1'b1, pin_drive.first_oe_n);
            pulse();
            tgt = (m == `MODE_CAP_FALL) ? fall_t : rise_t;
            rd(`ADDR_IRQ_STATUS, rv);
            chk("capture flag", 16'h0001, {8'h00, rv});
            rd(`ADDR_CAP_LOW, rv);
            rd(`ADDR_CAP_HIGH, hi);
            chk("captured timer", tgt, {hi, rv});
        end
        $display("test capture done");
        // pwm polarity codes, duty low bits and output configuration
        for (int w = 12; w <= 15; w++)
        begin
            m = 4'(w);
            hi = 8'h20 + (8'($random(seed)) & 8'h7f);
            rv = {m[0], 1'b0, 2'($random(seed)), m};
            duty = {hi, rv[5:4]};
            wr(`ADDR_CAP_LOW, hi);
            wr(`ADDR_MODE_CTRL, rv);
            wait_full(10'h3ff);
            wait_full(duty - 10'h001);
            @(negedge ref_clk);
            chk_bit("pwm active", pwm_lvl(m, 1'b1), pin_drive.first_out);
            chk_bit("pwm second idle", m[0], pin_drive.second_out);
            @(negedge ref_clk);
            chk_bit("pwm inactive", pwm_lvl(m, 1'b0), pin_drive.first_out);
            chk_bit("pwm second low", 1'b0, pin_drive.second_out);
            chk("pwm enables", {14'h0000, 1'b0, ~m[0]}, {14'h0000, pin_drive.first_oe_n,
                pin_drive.second_oe_n});
        end
        $display("test pwm done");
        report_and_stop();
    end
endmodule : enhanced_capture_compare_pwm_ctrl_bench
